/* sxs_exec.sv */
// Execution datapath with accumulator, flags, file registers, port direction
// registers, watchdog counter and sleep state, all reached over AHB-Lite.
// Assumes it is the only slave, so hready equals its own hreadyout.
// Behaviour
// RULE1: literal minus accumulator into accumulator
// RULE2: subtracts set carry, nibble carry, zero
// RULE3: register minus accumulator to destination
// RULE4: address 0..127; destination bit selects target
// RULE5: borrow subtract uses inverted carry
// RULE6: swap exchanges nibbles, flags untouched
// RULE7: literal exclusive-OR into accumulator, zero only
// RULE8: register exclusive-OR to destination, zero only
// RULE9: direction load picks port by 5,6,7
// RULE10: sleep clears powerdown, sets timeout flag
// RULE11: sleep clears watchdog counter and prescaler
// RULE12: sleep halts oscillator and execution
// RULE13: zero flag reflects eight-bit result
// RULE14: same-cycle write-back; unaffected flags held
`timescale 1ns/1ps
`default_nettype none
module sxs_exec #(
  parameter int FILE_DEPTH = 128,
  parameter logic [7:0] PRE_DIV = sxs_pkg::SXS_PRE_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic wake_req,
  output logic sleep_mode,
  output logic osc_enable,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output logic [7:0] watchdog_counter
);
  sxs_pkg::sxs_state_t s_q;
  sxs_pkg::sxs_state_t s_d;
  logic [7:0] file_mem [FILE_DEPTH];
  logic mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;
  logic wr_go;
  logic ex_go;
  sxs_pkg::sxs_op_t ex_op;
  logic [7:0] ex_opnd;
  logic ex_dest;
  logic [7:0] f_val;
  logic [7:0] minuend;
  logic borrow_in;
  logic [8:0] diff9;
  logic [4:0] diff5;
  logic [7:0] result;
  logic is_sub;
  logic is_xor;
  logic to_reg;
  logic addr_ok;

  // The slave never stalls, so every transfer completes without wait states.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && (htrans == sxs_pkg::SXS_HTRANS_NONSEQ);
  assign wr_go = s_q.wr_pend;
  assign ex_go = wr_go && (s_q.bus_addr == sxs_pkg::SXS_EXEC_OFS);
  assign ex_op = sxs_pkg::sxs_op_t'(hwdata[sxs_pkg::SXS_EX_OP_LSB +: 4]);
  assign ex_opnd = hwdata[sxs_pkg::SXS_EX_OPND_LSB +: 8];
  assign ex_dest = hwdata[sxs_pkg::SXS_EX_DEST];
  assign f_val = file_mem[ex_opnd[6:0]]; // RULE4

  // Subtract path shared by all three subtract operations.
  always_comb begin
    is_sub = (ex_op == sxs_pkg::SXS_OP_LIT_SUB) || (ex_op == sxs_pkg::SXS_OP_REG_SUB) ||
      (ex_op == sxs_pkg::SXS_OP_REG_SUBB);
    is_xor = (ex_op == sxs_pkg::SXS_OP_XOR_LIT) || (ex_op == sxs_pkg::SXS_OP_XOR_REG);
    minuend = (ex_op == sxs_pkg::SXS_OP_LIT_SUB) ? ex_opnd : f_val; // RULE1 RULE3
    borrow_in = (ex_op == sxs_pkg::SXS_OP_REG_SUBB) ? ~s_q.core.carry : 1'b0; // RULE5
    diff9 = {1'b0, minuend} - {1'b0, s_q.core.acc} - {8'h00, borrow_in};
    diff5 = {1'b0, minuend[3:0]} - {1'b0, s_q.core.acc[3:0]} - {4'h0, borrow_in};
    case (ex_op)
      sxs_pkg::SXS_OP_LIT_SUB, sxs_pkg::SXS_OP_REG_SUB, sxs_pkg::SXS_OP_REG_SUBB: begin
        result = diff9[7:0];
      end
      sxs_pkg::SXS_OP_SWAP: begin
        result = {f_val[3:0], f_val[7:4]}; // RULE6
      end
      sxs_pkg::SXS_OP_XOR_LIT: begin
        result = s_q.core.acc ^ ex_opnd; // RULE7
      end
      sxs_pkg::SXS_OP_XOR_REG: begin
        result = s_q.core.acc ^ f_val; // RULE8
      end
      default: begin
        result = s_q.core.acc;
      end
    endcase
    to_reg = ex_dest && (ex_op == sxs_pkg::SXS_OP_REG_SUB || ex_op == sxs_pkg::SXS_OP_REG_SUBB ||
      ex_op == sxs_pkg::SXS_OP_SWAP || ex_op == sxs_pkg::SXS_OP_XOR_REG); // RULE4
  end

  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_addr = ex_opnd[6:0];
    mem_wdata = result;
    // Address phase capture for the next data phase.
    s_d.wr_pend = addr_ok && hwrite && (hsize == sxs_pkg::SXS_HSIZE_WORD);
    s_d.rd_pend = addr_ok && !hwrite;
    if (addr_ok) begin
      s_d.bus_addr = haddr[7:0];
    end
    // The watchdog runs in both power states from its own slow tick.
    if (s_q.pre == PRE_DIV) begin
      s_d.pre = 8'h00;
      s_d.wdog = s_q.wdog + 8'h01;
    end else begin
      s_d.pre = s_q.pre + 8'h01;
    end
    if (s_q.pwr == sxs_pkg::SXS_PWR_SLEEP && wake_req) begin
      s_d.pwr = sxs_pkg::SXS_PWR_RUN;
    end
    if (wr_go) begin
      case (s_q.bus_addr)
        sxs_pkg::SXS_ACC_OFS: begin
          s_d.core.acc = hwdata[7:0];
        end
        sxs_pkg::SXS_STATUS_OFS: begin
          s_d.core.carry = hwdata[sxs_pkg::SXS_ST_CARRY];
          s_d.core.nib = hwdata[sxs_pkg::SXS_ST_NIB];
          s_d.core.zero = hwdata[sxs_pkg::SXS_ST_ZERO];
        end
        sxs_pkg::SXS_FADDR_OFS: begin
          s_d.faddr = hwdata[6:0];
        end
        sxs_pkg::SXS_FDATA_OFS: begin
          mem_we = 1'b1;
          mem_addr = s_q.faddr;
          mem_wdata = hwdata[7:0];
        end
        default: begin
        end
      endcase
    end
    // Instructions written while asleep are dropped: execution is gated on the run power state.
    if (ex_go && s_q.pwr == sxs_pkg::SXS_PWR_RUN) begin // RULE12
      if (is_sub) begin
        s_d.core.carry = ~diff9[8]; // RULE2
        s_d.core.nib = ~diff5[4]; // RULE2
      end
      if (is_sub || is_xor) begin
        s_d.core.zero = (result == 8'h00); // RULE13
      end
      if (is_sub || is_xor || ex_op == sxs_pkg::SXS_OP_SWAP) begin
        if (to_reg) begin
          mem_we = 1'b1; // RULE14
        end else begin
          s_d.core.acc = result; // RULE4
        end
      end
      if (ex_op == sxs_pkg::SXS_OP_DIR_LOAD) begin
        case (ex_opnd) // RULE9
          sxs_pkg::SXS_PORT_A_SEL: s_d.dir.a = s_q.core.acc;
          sxs_pkg::SXS_PORT_B_SEL: s_d.dir.b = s_q.core.acc;
          sxs_pkg::SXS_PORT_C_SEL: s_d.dir.c = s_q.core.acc;
          default: begin
          end
        endcase
      end
      if (ex_op == sxs_pkg::SXS_OP_SLEEP) begin
        s_d.core.pd = 1'b0; // RULE10
        s_d.core.to = 1'b1; // RULE10
        s_d.wdog = sxs_pkg::SXS_WDOG_CLR; // RULE11
        s_d.pre = 8'h00; // RULE11
        s_d.pwr = sxs_pkg::SXS_PWR_SLEEP; // RULE12
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.core.acc <= sxs_pkg::SXS_ACC_RST;
      s_q.core.pd <= sxs_pkg::SXS_PD_RST;
      s_q.core.to <= sxs_pkg::SXS_TO_RST;
      s_q.dir <= {sxs_pkg::SXS_DIR_RST, sxs_pkg::SXS_DIR_RST, sxs_pkg::SXS_DIR_RST};
      s_q.pwr <= sxs_pkg::SXS_PWR_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // File registers hold no reset value, as a plain RAM would.
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      file_mem[mem_addr] <= mem_wdata;
    end
  end

  // Read data is a mux of flops; a read right after a write sees the new value.
  always_comb begin
    hrdata = 32'h0000_0000;
    if (s_q.rd_pend) begin
      case (s_q.bus_addr)
        sxs_pkg::SXS_ACC_OFS: hrdata[7:0] = s_q.core.acc;
        sxs_pkg::SXS_STATUS_OFS: hrdata[4:0] = {s_q.core.to, s_q.core.pd, s_q.core.zero,
          s_q.core.nib, s_q.core.carry};
        sxs_pkg::SXS_DIR_OFS: hrdata[23:0] = {s_q.dir.c, s_q.dir.b, s_q.dir.a};
        sxs_pkg::SXS_WDOG_OFS: hrdata[16:0] = {(s_q.pwr == sxs_pkg::SXS_PWR_SLEEP),
          s_q.pre, s_q.wdog};
        sxs_pkg::SXS_FADDR_OFS: hrdata[6:0] = s_q.faddr;
        sxs_pkg::SXS_FDATA_OFS: hrdata[7:0] = file_mem[s_q.faddr];
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  assign sleep_mode = (s_q.pwr == sxs_pkg::SXS_PWR_SLEEP);
  assign osc_enable = (s_q.pwr == sxs_pkg::SXS_PWR_RUN); // RULE12
  assign port_a_direction = s_q.dir.a;
  assign port_b_direction = s_q.dir.b;
  assign port_c_direction = s_q.dir.c;
  assign watchdog_counter = s_q.wdog;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic run_ex;
  assign run_ex = ex_go && !sleep_mode;

  a_lit_sub_acc: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_LIT_SUB |=> // RULE1
    s_q.core.acc == $past(ex_opnd - s_q.core.acc)) else $error("literal subtract wrong");
  a_sub_carry: assert property (run_ex && is_sub && borrow_in == 1'b0 |=> // RULE2
    s_q.core.carry == ($past(s_q.core.acc) <= $past(minuend))) else $error("carry wrong");
  a_sub_nib: assert property (run_ex && is_sub && borrow_in == 1'b0 |=> // RULE2
    s_q.core.nib == ($past(s_q.core.acc[3:0]) <= $past(minuend[3:0])))
    else $error("nibble carry wrong");
  a_dest_acc: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_REG_SUB && !ex_dest |=> // RULE3
    s_q.core.acc == $past(f_val - s_q.core.acc)) else $error("register subtract wrong");
  a_dest_reg: assert property (run_ex && to_reg |-> mem_we && mem_addr == ex_opnd[6:0] // RULE4
    ##1 s_q.core.acc == $past(s_q.core.acc)) else $error("destination wrong");
  a_borrow_sub: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_REG_SUBB && !ex_dest |=> // RULE5
    s_q.core.acc == $past(f_val - s_q.core.acc - {7'h00, ~s_q.core.carry}))
    else $error("borrow subtract wrong");
  a_swap_flags: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_SWAP |=> // RULE6
    s_q.core.carry == $past(s_q.core.carry) && s_q.core.nib == $past(s_q.core.nib) &&
    s_q.core.zero == $past(s_q.core.zero) &&
    ($past(ex_dest) || s_q.core.acc == {$past(f_val[3:0]), $past(f_val[7:4])}))
    else $error("swap changed flags");
  a_xor_flags: assert property (run_ex && is_xor |=> s_q.core.carry == $past(s_q.core.carry) && // RULE7 RULE8
    s_q.core.nib == $past(s_q.core.nib)) else $error("xor touched carry");
  a_dir_load: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_DIR_LOAD && // RULE9
    ex_opnd == sxs_pkg::SXS_PORT_B_SEL |=> port_b_direction == $past(s_q.core.acc) &&
    $stable(port_a_direction) && $stable(port_c_direction)) else $error("direction load wrong");
  a_sleep_flags: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_SLEEP |=> // RULE10
    !s_q.core.pd && s_q.core.to) else $error("sleep flags wrong");
  a_sleep_wdog: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_SLEEP |=> // RULE11
    watchdog_counter == 8'h00 && s_q.pre == 8'h00) else $error("watchdog not cleared");
  a_sleep_halt: assert property (sleep_mode && !wake_req |=> sleep_mode && !osc_enable) // RULE12
    else $error("sleep left without wake");
  a_zero_flag: assert property (run_ex && is_xor |=> s_q.core.zero == // RULE13
    ($past(result) == 8'h00)) else $error("zero flag wrong");
  a_reg_hold: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_DIR_LOAD |=> // RULE14
    s_q.core == $past(s_q.core)) else $error("flags not held");
  // Borrow, drop-while-asleep and write-back checks guard paths that simple
  // directed tests tend to miss, so they are kept apart from the ones above.
  a_sub_zero: assert property (run_ex && is_sub |=> s_q.core.zero == // RULE13
    ($past(minuend - s_q.core.acc - {7'h00, borrow_in}) == 8'h00))
    else $error("subtract zero flag wrong");
  a_subb_carry: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_REG_SUBB |=> // RULE5
    s_q.core.carry == ({1'b0, $past(s_q.core.acc)} + {8'h00, $past(borrow_in)} <=
    {1'b0, $past(f_val)})) else $error("borrow carry wrong");
  a_subb_nib: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_REG_SUBB |=> // RULE2
    s_q.core.nib == ({1'b0, $past(s_q.core.acc[3:0])} + {4'h0, $past(borrow_in)} <=
    {1'b0, $past(f_val[3:0])})) else $error("borrow nibble carry wrong");
  a_sleep_drop: assert property (ex_go && sleep_mode |=> // RULE12
    s_q.core == $past(s_q.core) && $stable(s_q.dir))
    else $error("instruction ran while asleep");
  a_xor_reg_acc: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_XOR_REG && // RULE8
    !ex_dest |=> s_q.core.acc == $past(s_q.core.acc ^ f_val))
    else $error("register xor wrong");
  a_swap_reg: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_SWAP && ex_dest |-> // RULE6
    mem_we && mem_wdata == {f_val[3:0], f_val[7:4]}) else $error("swap write-back wrong");
  a_dir_other: assert property (run_ex && ex_op == sxs_pkg::SXS_OP_DIR_LOAD && // RULE9
    (ex_opnd < sxs_pkg::SXS_PORT_A_SEL || ex_opnd > sxs_pkg::SXS_PORT_C_SEL) |=>
    $stable(s_q.dir)) else $error("direction load to unknown port");
  a_lit_no_write: assert property (run_ex && // RULE4
    (ex_op == sxs_pkg::SXS_OP_LIT_SUB || ex_op == sxs_pkg::SXS_OP_XOR_LIT) |-> !mem_we)
    else $error("literal op wrote a file register");
  a_wdog_tick: assert property (!(run_ex && ex_op == sxs_pkg::SXS_OP_SLEEP) && // RULE11
    s_q.pre == PRE_DIV |=> watchdog_counter == $past(watchdog_counter) + 8'h01)
    else $error("watchdog did not advance");

  c_sub_borrow: cover property (run_ex && ex_op == sxs_pkg::SXS_OP_REG_SUBB && borrow_in);
  c_reg_write: cover property (run_ex && to_reg);
  c_sleep_wake: cover property (sleep_mode ##1 wake_req ##1 !sleep_mode);
  c_dir_load: cover property (run_ex && ex_op == sxs_pkg::SXS_OP_DIR_LOAD);
  c_sub_zero: cover property (run_ex && is_sub && result == 8'h00);
endmodule
`default_nettype wire

/* sxs_pkg.sv */
// Package for the subtract, exclusive-OR, swap and sleep execution block.
// Assumes one core clock and an AHB-Lite master with single word transfers.
package sxs_pkg;
  localparam logic [7:0] SXS_ACC_OFS = 8'h00;
  localparam logic [7:0] SXS_STATUS_OFS = 8'h04;
  localparam logic [7:0] SXS_EXEC_OFS = 8'h08;
  localparam logic [7:0] SXS_DIR_OFS = 8'h0C;
  localparam logic [7:0] SXS_WDOG_OFS = 8'h10;
  localparam logic [7:0] SXS_FADDR_OFS = 8'h14;
  localparam logic [7:0] SXS_FDATA_OFS = 8'h18;
  localparam int SXS_ST_CARRY = 0;
  localparam int SXS_ST_NIB = 1;
  localparam int SXS_ST_ZERO = 2;
  localparam int SXS_ST_PD = 3;
  localparam int SXS_ST_TO = 4;
  localparam int SXS_EX_OPND_LSB = 0;
  localparam int SXS_EX_OP_LSB = 8;
  localparam int SXS_EX_DEST = 12;
  localparam logic [7:0] SXS_ACC_RST = 8'h00;
  localparam logic [7:0] SXS_DIR_RST = 8'hFF;
  localparam logic SXS_PD_RST = 1'b1;
  localparam logic SXS_TO_RST = 1'b1;
  localparam logic [7:0] SXS_WDOG_CLR = 8'h00;
  localparam logic [7:0] SXS_PORT_A_SEL = 8'h05;
  localparam logic [7:0] SXS_PORT_B_SEL = 8'h06;
  localparam logic [7:0] SXS_PORT_C_SEL = 8'h07;
  localparam logic [7:0] SXS_PRE_DIV = 8'hFF;
  localparam logic [1:0] SXS_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SXS_HSIZE_WORD = 3'h2;

  typedef enum logic [3:0] {
    SXS_OP_NONE = 4'h0,
    SXS_OP_LIT_SUB = 4'h1,
    SXS_OP_REG_SUB = 4'h2,
    SXS_OP_REG_SUBB = 4'h3,
    SXS_OP_SWAP = 4'h4,
    SXS_OP_XOR_LIT = 4'h5,
    SXS_OP_XOR_REG = 4'h6,
    SXS_OP_DIR_LOAD = 4'h7,
    SXS_OP_SLEEP = 4'h8
  } sxs_op_t;

  typedef enum logic [1:0] {
    SXS_PWR_RUN = 2'h1,
    SXS_PWR_SLEEP = 2'h2
  } sxs_pwr_t;

  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic nib;
    logic zero;
    logic pd;
    logic to;
  } sxs_core_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } sxs_dir_t;

  typedef struct packed {
    sxs_core_t core;
    sxs_dir_t dir;
    logic [7:0] wdog;
    logic [7:0] pre;
    sxs_pwr_t pwr;
    logic [6:0] faddr;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] bus_addr;
  } sxs_state_t;
endpackage

/* sxs_host.sv */
// AHB-Lite master that stands in for the instruction decoder.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ps
`default_nettype none
module sxs_host (
  input wire logic ref_clk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  logic [31:0] cap_q;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
  end
  // Capturing the pre-edge value avoids a race with the slave's own flops.
  always @(posedge ref_clk) begin
    cap_q <= hrdata;
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= sxs_pkg::SXS_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sxs_pkg::SXS_HSIZE_WORD;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    #1 q = cap_q;
  endtask
endmodule
`default_nettype wire

/* sxs_exec_bench.sv */
// Self-checking bench for the execution block, driven over AHB-Lite.
// Assumes the host model is the only master and a short prescaler of 3.
`timescale 1ns/1ps
`default_nettype none
module sxs_exec_bench;
  logic ref_clk, rst_n, wake_req, hsel, hwrite, hready, hresp;
  logic sleep_mode, osc_enable;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [7:0] pa, pb, pc, wd;
  int err_count;
  int num_checks;
  sxs_exec #(.PRE_DIV(8'h03)) u_sxs_exec (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .wake_req(wake_req), .sleep_mode(sleep_mode), .osc_enable(osc_enable),
    .port_a_direction(pa), .port_b_direction(pb), .port_c_direction(pc),
    .watchdog_counter(wd));
  sxs_host u_sxs_host (
    .ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_sxs_host.xfer(a, 1'b1, d, rv);
  endtask
  task automatic rchk(input logic [7:0] a, input string n, input logic [31:0] e);
    u_sxs_host.xfer(a, 1'b0, 32'h0, rv);
    chk(n, e, rv);
  endtask
  task automatic ex(input sxs_pkg::sxs_op_t op, input logic [7:0] k, input logic dst);
    wr(sxs_pkg::SXS_EXEC_OFS, {19'h0, dst, op, k});
  endtask
  task automatic state(input logic [7:0] acc, input logic [7:0] st);
    rchk(sxs_pkg::SXS_ACC_OFS, "acc", {24'h0, acc});
    rchk(sxs_pkg::SXS_STATUS_OFS, "status", {24'h0, st});
  endtask
  task automatic setf(input logic [6:0] a, input logic [7:0] d);
    wr(sxs_pkg::SXS_FADDR_OFS, {25'h0, a});
    wr(sxs_pkg::SXS_FDATA_OFS, {24'h0, d});
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(3000 * 100);
    err_count++;
    end_sim;
  end
  initial begin
    rst_n = 1'b0;
    wake_req = 1'b0;
    err_count = 0;
    num_checks = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    state(8'h00, 8'h18);
    wr(sxs_pkg::SXS_ACC_OFS, 32'h05);
    ex(sxs_pkg::SXS_OP_LIT_SUB, 8'h03, 1'b0);
    state(8'hFE, 8'h18);
    ex(sxs_pkg::SXS_OP_LIT_SUB, 8'hFE, 1'b0);
    state(8'h00, 8'h1F);
    setf(7'h7F, 8'h23);
    wr(sxs_pkg::SXS_ACC_OFS, 32'h14);
    ex(sxs_pkg::SXS_OP_REG_SUB, 8'h7F, 1'b1);
    rchk(sxs_pkg::SXS_FDATA_OFS, "file", 32'h0F);
    state(8'h14, 8'h19);
    wr(sxs_pkg::SXS_STATUS_OFS, 32'h0);
    setf(7'h02, 8'h10);
    wr(sxs_pkg::SXS_ACC_OFS, 32'h05);
    ex(sxs_pkg::SXS_OP_REG_SUBB, 8'h02, 1'b0);
    state(8'h0A, 8'h19);
    ex(sxs_pkg::SXS_OP_REG_SUBB, 8'h02, 1'b0);
    state(8'h06, 8'h19);
    setf(7'h03, 8'hA5);
    wr(sxs_pkg::SXS_STATUS_OFS, 32'h07);
    ex(sxs_pkg::SXS_OP_SWAP, 8'h03, 1'b0);
    state(8'h5A, 8'h1F);
    ex(sxs_pkg::SXS_OP_SWAP, 8'h03, 1'b1);
    rchk(sxs_pkg::SXS_FDATA_OFS, "file", 32'h5A);
    wr(sxs_pkg::SXS_STATUS_OFS, 32'h01);
    ex(sxs_pkg::SXS_OP_XOR_LIT, 8'h5A, 1'b1);
    state(8'h00, 8'h1D);
    wr(sxs_pkg::SXS_ACC_OFS, 32'h0F);
    ex(sxs_pkg::SXS_OP_XOR_REG, 8'h03, 1'b1);
    rchk(sxs_pkg::SXS_FDATA_OFS, "file", 32'h55);
    state(8'h0F, 8'h19);
    for (int i = 4; i < 8; i++) begin
      wr(sxs_pkg::SXS_ACC_OFS, 32'h10 + i);
      ex(sxs_pkg::SXS_OP_DIR_LOAD, 8'(i), 1'b0);
    end
    rchk(sxs_pkg::SXS_DIR_OFS, "dir", 32'h00171615);
    chk("ports", 32'h00171615, {8'h0, pc, pb, pa});
    state(8'h17, 8'h19);
    ex(sxs_pkg::SXS_OP_XOR_REG, 8'h03, 1'b0);
    state(8'h42, 8'h19);
    ex(sxs_pkg::SXS_OP_SLEEP, 8'h00, 1'b0);
    chk("wdog", 32'h0, {24'h0, wd});
    chk("sleep", 32'h1, {31'h0, sleep_mode});
    chk("osc", 32'h0, {31'h0, osc_enable});
    rchk(sxs_pkg::SXS_WDOG_OFS, "wdog", 32'h00010200);
    rchk(sxs_pkg::SXS_STATUS_OFS, "status", 32'h11);
    ex(sxs_pkg::SXS_OP_XOR_LIT, 8'hFF, 1'b0);
    @(posedge ref_clk);
    wake_req <= 1'b1;
    @(posedge ref_clk);
    wake_req <= 1'b0;
    #1;
    chk("awake", 32'h1, {31'h0, osc_enable});
    state(8'h42, 8'h11);
    chk("hresp", 32'h0, {31'h0, hresp});
    end_sim;
  end
endmodule
`default_nettype wire
